// ==== vic_controller.sv ====
// Purpose: Request gathering, enabling and four-level arbitration for the core
// Assumes: Peripheral set pulses on clk; external inputs asynchronous
// Notes: AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ps
`include "vic_params.svh"

module vic_controller
   import vic_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [`VIC_FLAG_W-1:0] flagSetPulse,
   input wire logic [3:0] extIrqPin,
   input wire logic vectorAck,
   input wire logic retiPulse,
   output logic irqRequest,
   output logic [4:0] irqSource,
   output logic [1:0] irqPriority
);

////////////////////////////////////////////////////////////////////////////////
// Functions

   // Place four external values at their flag positions
   function automatic logic [`VIC_FLAG_W-1:0] placeExt(input logic [3:0] v);
      logic [`VIC_FLAG_W-1:0] r;
      r = `VIC_RST_FLAGS;
      r[`VIC_F_EXT0] = v[0];
      r[`VIC_F_EXT1] = v[1];
      r[`VIC_F_EXT2] = v[2];
      r[`VIC_F_EXT3] = v[3];
      return r;
   endfunction

   // Flags hardware clears when a source is vectored to
   function automatic logic [`VIC_FLAG_W-1:0] srcClr(input logic [4:0] s);
      logic [`VIC_FLAG_W-1:0] r;
      r = `VIC_RST_FLAGS;
      case (s)
         `VIC_SRC_T0: r[`VIC_F_T0] = 1'b1;
         `VIC_SRC_T1: r[`VIC_F_T1] = 1'b1;
         `VIC_SRC_EXT0: r[`VIC_F_EXT0] = 1'b1;
         `VIC_SRC_EXT1: r[`VIC_F_EXT1] = 1'b1;
         `VIC_SRC_EXT2: r[`VIC_F_EXT2] = 1'b1;
         `VIC_SRC_EXT3: r[`VIC_F_EXT3] = 1'b1;
         default: r = `VIC_RST_FLAGS;
      endcase
      return r;
   endfunction

   // Highest active level plus one, zero when none runs
   function automatic logic [2:0] ceilingOf(input logic [3:0] a);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (a[i])
         begin
            r = 3'(i + 1);
         end
      end
      return r;
   endfunction

   // One-hot of the highest active level
   function automatic logic [3:0] topBit(input logic [3:0] a);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (a[i])
         begin
            r = 4'(1 << i);
         end
      end
      return r;
   endfunction

   // Winner: highest level, lowest number on ties; {found, source, level}
   function automatic logic [7:0] pick(input logic [`VIC_NSRC-1:0] p,
                                       input logic [`VIC_NSRC-1:0] hi,
                                       input logic [`VIC_NSRC-1:0] lo);
      logic [7:0] r;
      r = 8'h00;
      for (int i = `VIC_NSRC - 1; i >= 0; i--)
      begin
         if (p[i] && (!r[7] || {hi[i], lo[i]} >= r[1:0]))
         begin
            r = {1'b1, 5'(i), hi[i], lo[i]};
         end
      end
      return r;
   endfunction

////////////////////////////////////////////////////////////////////////////////
// Declarations

   logic [1:0] rstSync_ff;
   logic rstN;
   logic [3:0] extMeta_ff;
   logic [3:0] extSync_ff;
   logic [3:0] extPrevAct_ff;
   logic [3:0] extAct;
   logic wrEn_ff;
   logic [`VIC_ADDR_W-1:0] wrAddr_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic hresp_ff;
   logic [7:0] enMain_ff;
   logic [`VIC_XC_W-1:0] extCtrl_ff;
   logic [7:0] enExt1_ff;
   logic [7:0] enExt2_ff;
   logic [`VIC_NSRC-1:0] priHigh_ff;
   logic [`VIC_NSRC-1:0] priLow_ff;
   logic [`VIC_FLAG_W-1:0] flags_ff;
   logic [3:0] active_ff;
   vic_state_t state_ff;
   vic_state_t nxt_state;
   logic irqRequest_ff;
   logic [4:0] irqSource_ff;
   logic [1:0] irqPriority_ff;

////////////////////////////////////////////////////////////////////////////////
// Reset release and pin synchronisers

   // Reset is released through two flip-flops
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rstSync_ff <= 2'h0;
      else
         rstSync_ff <= {rstSync_ff[0], 1'b1};
   end
   assign rstN = rstSync_ff[1];

   // External inputs cross into clk before any use
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         extMeta_ff <= 4'h0;
         extSync_ff <= 4'h0;
         extPrevAct_ff <= 4'hf;
      end
      else
      begin
         extMeta_ff <= extIrqPin;
         extSync_ff <= extMeta_ff;
         extPrevAct_ff <= extAct;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Bus decode

   wire addrPhase = hsel & htrans[1] & hready;
   wire [`VIC_ADDR_W-1:0] busAddr = haddr[`VIC_ADDR_W-1:0];
   wire wrMain = wrEn_ff && wrAddr_ff == `VIC_OFS_EN_MAIN;
   wire wrXc = wrEn_ff && wrAddr_ff == `VIC_OFS_EXT_CTRL;
   wire wrExt1 = wrEn_ff && wrAddr_ff == `VIC_OFS_EN_EXT1;
   wire wrExt2 = wrEn_ff && wrAddr_ff == `VIC_OFS_EN_EXT2;
   wire wrPriH = wrEn_ff && wrAddr_ff == `VIC_OFS_PRI_HIGH;
   wire wrPriL = wrEn_ff && wrAddr_ff == `VIC_OFS_PRI_LOW;
   wire wrFlA = wrEn_ff && wrAddr_ff == `VIC_OFS_FLAGS_A;
   wire wrFlB = wrEn_ff && wrAddr_ff == `VIC_OFS_FLAGS_B;

////////////////////////////////////////////////////////////////////////////////
// Next register values

   // Control registers take the data phase word
   wire [7:0] nxt_enMain = wrMain ? (hwdata[7:0] & `VIC_EN_MAIN_MASK) : enMain_ff;
   wire [`VIC_XC_W-1:0] nxt_extCtrl = wrXc ? hwdata[`VIC_XC_W-1:0] : extCtrl_ff;
   wire [7:0] nxt_enExt1 = wrExt1 ? hwdata[7:0] : enExt1_ff;
   wire [7:0] nxt_enExt2 = wrExt2 ? hwdata[7:0] : enExt2_ff;
   wire [`VIC_NSRC-1:0] nxt_priHigh = wrPriH ? hwdata[`VIC_NSRC-1:0] : priHigh_ff;
   wire [`VIC_NSRC-1:0] nxt_priLow = wrPriL ? hwdata[`VIC_NSRC-1:0] : priLow_ff;

   // External trigger: polarity, edge or level
   wire [3:0] extHigh = extCtrl_ff[`VIC_XC_HIGH_HI:`VIC_XC_HIGH_LO];
   wire [3:0] extEdgeMode = {extCtrl_ff[`VIC_XC_TYPE3], extCtrl_ff[`VIC_XC_TYPE2],
                             extCtrl_ff[`VIC_XC_TYPE1], extCtrl_ff[`VIC_XC_TYPE0]};
   assign extAct = ~(extSync_ff ^ extHigh);
   wire [3:0] extEdge = extAct & ~extPrevAct_ff & extEdgeMode;
   wire [`VIC_FLAG_W-1:0] levelMask = placeExt(~extEdgeMode);
   wire [`VIC_FLAG_W-1:0] levelVal = placeExt(extAct);

   // Hand-off to the core
   wire take = vectorAck & (state_ff == VIC_OFFER);
   wire [`VIC_FLAG_W-1:0] ackClr = take ? srcClr(irqSource_ff) : `VIC_RST_FLAGS;

   // Flags: software write, then vector clear, then hardware set wins
   wire [`VIC_FLAG_W-1:0] swBase = {wrFlB ? hwdata[`VIC_FLAGB_W-1:0] : flags_ff[`VIC_FLAG_W-1:32],
                                    wrFlA ? hwdata : flags_ff[31:0]};
   wire [`VIC_FLAG_W-1:0] hwSet = (flagSetPulse & ~placeExt(4'hf)) | placeExt(extEdge);
   wire [`VIC_FLAG_W-1:0] flagsCore = (swBase & ~ackClr) | hwSet;
   wire [`VIC_FLAG_W-1:0] nxt_flags = (flagsCore & ~levelMask) | (levelVal & levelMask);

   // Routine levels: return frees the top one, vectoring adds one
   wire [3:0] retiClr = retiPulse ? topBit(active_ff) : 4'h0;
   wire [3:0] takeSet = take ? 4'(1 << irqPriority_ff) : 4'h0;
   wire [3:0] nxt_active = (active_ff & ~retiClr) | takeSet;

////////////////////////////////////////////////////////////////////////////////
// Source requests

   wire [`VIC_FLAG_W-1:0] f = flags_ff;
   wire sysReq = f[`VIC_F_START] | f[`VIC_F_STOP]
               | (extCtrl_ff[`VIC_XC_ROUTE] & f[`VIC_F_U0TX]);
   wire sysReqAll = sysReq | f[`VIC_F_MCD] | f[`VIC_F_RTC] | f[`VIC_F_BO0]
                  | f[`VIC_F_BO1] | f[`VIC_F_WDT];
   wire [`VIC_NSRC-1:0] srcReq;
   assign srcReq[0] = f[`VIC_F_EXT0];
   assign srcReq[1] = f[`VIC_F_T0];
   assign srcReq[2] = f[`VIC_F_EXT1];
   assign srcReq[3] = f[`VIC_F_T1];
   assign srcReq[4] = f[`VIC_F_U0RX] | f[`VIC_F_U0TX];
   assign srcReq[5] = f[`VIC_F_T2OVF] | f[`VIC_F_T2EXT];
   assign srcReq[6] = f[`VIC_F_EXT2];
   assign srcReq[7] = f[`VIC_F_EXT3];
   assign srcReq[8] = f[`VIC_F_SPI];
   assign srcReq[9] = f[`VIC_F_ADC];
   assign srcReq[10] = |f[`VIC_F_ARR0_HI:`VIC_F_ARR0_LO];
   assign srcReq[11] = sysReqAll;
   assign srcReq[12] = f[`VIC_F_U1RX] | f[`VIC_F_U1TX];
   assign srcReq[13] = f[`VIC_F_KEY];
   assign srcReq[14] = f[`VIC_F_TW0];
   assign srcReq[15] = f[`VIC_F_AC0];
   assign srcReq[16] = f[`VIC_F_T3OVF] | f[`VIC_F_T3EXT] | f[`VIC_F_T3LOW];
   assign srcReq[17] = f[`VIC_F_AC1];
   assign srcReq[18] = f[`VIC_F_U2RX] | f[`VIC_F_U2TX];
   assign srcReq[19] = f[`VIC_F_T4OVF] | f[`VIC_F_T4EXT] | f[`VIC_F_T4LOW];
   assign srcReq[20] = f[`VIC_F_U3RX] | f[`VIC_F_U3TX];
   assign srcReq[21] = |f[`VIC_F_ARR1_HI:`VIC_F_ARR1_LO];
   assign srcReq[22] = f[`VIC_F_TW1];
   assign srcReq[23] = f[`VIC_F_AC2];

   // Enables in source order
   wire [`VIC_NSRC-1:0] srcEn = {enExt2_ff, enExt1_ff, extCtrl_ff[`VIC_XC_EN3],
                                 extCtrl_ff[`VIC_XC_EN2], enMain_ff[5:0]};

   // Only levels above the running routine may be offered
   wire [2:0] ceiling = ceilingOf(active_ff);
   logic [`VIC_NSRC-1:0] aboveRun;
   always_comb
   begin
      for (int i = 0; i < `VIC_NSRC; i++)
      begin
         aboveRun[i] = {1'b0, priHigh_ff[i], priLow_ff[i]} >= ceiling;
      end
   end

   wire [`VIC_NSRC-1:0] pending = srcReq & srcEn & {`VIC_NSRC{enMain_ff[`VIC_EN_GLOBAL]}};
   wire [7:0] win = pick(pending & aboveRun, priHigh_ff, priLow_ff);
   wire winFound = win[7];

////////////////////////////////////////////////////////////////////////////////
// Offer state

   // A taken offer drops for one cycle so cleared flags settle
   always_comb
   begin
      unique case (state_ff)
         VIC_IDLE: nxt_state = winFound ? VIC_OFFER : VIC_IDLE;
         VIC_OFFER: nxt_state = (take || !winFound) ? VIC_IDLE : VIC_OFFER;
      endcase
   end

////////////////////////////////////////////////////////////////////////////////
// Read mux, from next values so a write shows at once

   wire [31:0] status = {20'h0, irqPriority_ff, irqSource_ff, irqRequest_ff, nxt_active};
   wire [31:0] readVal =
      (busAddr == `VIC_OFS_EN_MAIN) ? {24'h0, nxt_enMain} :
      (busAddr == `VIC_OFS_EXT_CTRL) ? {21'h0, nxt_extCtrl} :
      (busAddr == `VIC_OFS_EN_EXT1) ? {24'h0, nxt_enExt1} :
      (busAddr == `VIC_OFS_EN_EXT2) ? {24'h0, nxt_enExt2} :
      (busAddr == `VIC_OFS_PRI_HIGH) ? {8'h0, nxt_priHigh} :
      (busAddr == `VIC_OFS_PRI_LOW) ? {8'h0, nxt_priLow} :
      (busAddr == `VIC_OFS_FLAGS_A) ? nxt_flags[31:0] :
      (busAddr == `VIC_OFS_FLAGS_B) ? {13'h0, nxt_flags[`VIC_FLAG_W-1:32]} :
      (busAddr == `VIC_OFS_STATUS) ? status : 32'h0;

////////////////////////////////////////////////////////////////////////////////
// Bus slave registers

   // Address phase captured; slave never stalls
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrEn_ff <= 1'b0;
         wrAddr_ff <= 6'h00;
         hrdata_ff <= 32'h0;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end
      else
      begin
         wrEn_ff <= addrPhase & hwrite;
         wrAddr_ff <= busAddr;
         hrdata_ff <= (addrPhase & ~hwrite) ? readVal : 32'h0;
         hreadyout_ff <= 1'b1;
         hresp_ff <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Control and flag registers

   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         enMain_ff <= `VIC_RST_BYTE;
         extCtrl_ff <= `VIC_RST_XC;
         enExt1_ff <= `VIC_RST_BYTE;
         enExt2_ff <= `VIC_RST_BYTE;
         priHigh_ff <= `VIC_RST_PRI;
         priLow_ff <= `VIC_RST_PRI;
         flags_ff <= `VIC_RST_FLAGS;
      end
      else
      begin
         enMain_ff <= nxt_enMain;
         extCtrl_ff <= nxt_extCtrl;
         enExt1_ff <= nxt_enExt1;
         enExt2_ff <= nxt_enExt2;
         priHigh_ff <= nxt_priHigh;
         priLow_ff <= nxt_priLow;
         flags_ff <= nxt_flags;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// Arbitration outputs

   // Offer holds the current winner while in the offer state
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_ff <= VIC_IDLE;
         active_ff <= 4'h0;
         irqRequest_ff <= 1'b0;
         irqSource_ff <= 5'h00;
         irqPriority_ff <= 2'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         active_ff <= nxt_active;
         irqRequest_ff <= (nxt_state == VIC_OFFER);
         irqSource_ff <= (nxt_state == VIC_OFFER) ? win[6:2] : irqSource_ff;
         irqPriority_ff <= (nxt_state == VIC_OFFER) ? win[1:0] : irqPriority_ff;
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;
   assign irqRequest = irqRequest_ff;
   assign irqSource = irqSource_ff;
   assign irqPriority = irqPriority_ff;

endmodule

// ==== vic_params.svh ====
// Purpose: Named offsets, bit positions and reset values for the interrupt controller
// Assumes: Included by the controller and by the package user files
// Notes: Definitions only
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH

// Register byte offsets on the bus
`define VIC_ADDR_W 6
`define VIC_OFS_EN_MAIN 6'h00
`define VIC_OFS_EXT_CTRL 6'h04
`define VIC_OFS_EN_EXT1 6'h08
`define VIC_OFS_EN_EXT2 6'h0c
`define VIC_OFS_PRI_HIGH 6'h10
`define VIC_OFS_PRI_LOW 6'h14
`define VIC_OFS_FLAGS_A 6'h18
`define VIC_OFS_FLAGS_B 6'h1c
`define VIC_OFS_STATUS 6'h20

// Widths and reset values
`define VIC_NSRC 24
`define VIC_FLAG_W 51
`define VIC_FLAGB_W 19
`define VIC_XC_W 11
`define VIC_RST_BYTE 8'h00
`define VIC_RST_XC 11'h000
`define VIC_RST_PRI 24'h000000
`define VIC_RST_FLAGS 51'h0
`define VIC_EN_MAIN_MASK 8'hbf

// Main enable and external control bit positions
`define VIC_EN_GLOBAL 7
`define VIC_XC_TYPE0 0
`define VIC_XC_TYPE1 1
`define VIC_XC_EN2 2
`define VIC_XC_EN3 3
`define VIC_XC_TYPE2 4
`define VIC_XC_TYPE3 5
`define VIC_XC_HIGH_LO 6
`define VIC_XC_HIGH_HI 9
`define VIC_XC_ROUTE 10

// Request flag positions in the flag vector
`define VIC_F_EXT0 0
`define VIC_F_T0 1
`define VIC_F_EXT1 2
`define VIC_F_T1 3
`define VIC_F_U0RX 4
`define VIC_F_U0TX 5
`define VIC_F_T2OVF 6
`define VIC_F_T2EXT 7
`define VIC_F_EXT2 8
`define VIC_F_EXT3 9
`define VIC_F_SPI 10
`define VIC_F_ADC 11
`define VIC_F_MCD 12
`define VIC_F_RTC 13
`define VIC_F_BO0 14
`define VIC_F_BO1 15
`define VIC_F_WDT 16
`define VIC_F_START 17
`define VIC_F_STOP 18
`define VIC_F_U1RX 19
`define VIC_F_U1TX 20
`define VIC_F_KEY 21
`define VIC_F_TW0 22
`define VIC_F_AC0 23
`define VIC_F_T3OVF 24
`define VIC_F_T3EXT 25
`define VIC_F_T3LOW 26
`define VIC_F_AC1 27
`define VIC_F_U2RX 28
`define VIC_F_U2TX 29
`define VIC_F_T4OVF 30
`define VIC_F_T4EXT 31
`define VIC_F_T4LOW 32
`define VIC_F_U3RX 33
`define VIC_F_U3TX 34
`define VIC_F_TW1 35
`define VIC_F_AC2 36
`define VIC_F_ARR0_LO 37
`define VIC_F_ARR0_HI 43
`define VIC_F_ARR1_LO 44
`define VIC_F_ARR1_HI 50

// Source numbers whose flags hardware clears on vectoring
`define VIC_SRC_EXT0 5'h00
`define VIC_SRC_T0 5'h01
`define VIC_SRC_EXT1 5'h02
`define VIC_SRC_T1 5'h03
`define VIC_SRC_EXT2 5'h06
`define VIC_SRC_EXT3 5'h07

`endif

// ==== vic_pkg.sv ====
// Purpose: Types shared by the interrupt controller
// Assumes: Nothing
// Notes: Offer state is Gray coded
package vic_pkg;
   typedef enum logic [0:0]
   {
      VIC_IDLE = 1'b0,
      VIC_OFFER = 1'b1
   } vic_state_t;
endpackage

// ==== vic_controller_assertions.sv ====
// Purpose: Port-level checks of the interrupt controller
// Assumes: hready tied to hreadyout
// Notes: Bound to every vic_controller instance
`timescale 1ns/1ps
`include "vic_params.svh"
module vic_controller_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic vectorAck,
   input wire logic retiPulse,
   input wire logic irqRequest,
   input wire logic [4:0] irqSource,
   input wire logic [1:0] irqPriority
);
   logic rdPh_ff, wrMain_ff, gEn_ff;
   logic [3:0] act_ff;
   wire takeAck = vectorAck && irqRequest;
   wire busTake = hsel && htrans[1] && hready;
   wire [3:0] retiClr = act_ff[3] ? 4'h8 : act_ff[2] ? 4'h4 : act_ff[1] ? 4'h2 : {3'h0, act_ff[0]};
   wire [3:0] nxt_act = (act_ff & ~(retiPulse ? retiClr : 4'h0)) | (takeAck ? (4'h1 << irqPriority) : 4'h0);

   ////////////////////////////////////////////////////////////////
   // Shadow of running levels, read phases and the global gate
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         act_ff <= 4'h0;
         rdPh_ff <= 1'b0;
         wrMain_ff <= 1'b0;
         gEn_ff <= 1'b0;
      end
      else
      begin
         act_ff <= nxt_act;
         rdPh_ff <= busTake && !hwrite;
         wrMain_ff <= busTake && hwrite && haddr[5:0] == `VIC_OFS_EN_MAIN;
         gEn_ff <= wrMain_ff ? hwdata[`VIC_EN_GLOBAL] : gEn_ff;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_taken;
      vectorAck && irqRequest;
   endsequence
   a_ready_high: assert property (hreadyout == 1'b1) else $error("hreadyout low");
   a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
   a_rdata_idle: assert property (!rdPh_ff |-> hrdata == 32'h0) else $error("hrdata outside read");
   a_ack_drops: assert property (s_taken |=> !irqRequest) else $error("offer kept after ack");
   a_source_range: assert property (irqRequest |-> irqSource <= 5'h17) else $error("bad source");
   a_no_preempt: assert property (irqRequest |-> (act_ff >> irqPriority) == 4'h0)
      else $error("offer not above running level");
   a_global_gate: assert property (!gEn_ff |=> !irqRequest) else $error("offer while gated");
   a_reset_quiet: assert property ($rose(rst_b) |-> !irqRequest && irqPriority == 2'h0)
      else $error("offer at reset release");
endmodule
bind vic_controller vic_controller_checker u_vic_controller_checker (.clk(clk), .rst_b(rst_b), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .vectorAck(vectorAck), .retiPulse(retiPulse),
   .irqRequest(irqRequest), .irqSource(irqSource), .irqPriority(irqPriority));

// ==== vic_core_model.sv ====
// Purpose: Core sequencer that takes offers and returns from routines
// Assumes: Same clock as the controller
// Notes: ackDelay sets prompt or slow acceptance
`timescale 1ns/1ps
module vic_core_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic irqRequest,
   input wire logic [4:0] irqSource,
   input wire logic [1:0] irqPriority,
   input wire logic ackEn,
   input wire logic [3:0] ackDelay,
   input wire logic retiReq,
   output logic vectorAck,
   output logic retiPulse,
   output logic [4:0] lastSrc,
   output logic [1:0] lastPri,
   output logic [7:0] ackCount
);
   logic [3:0] cnt_ff;
   wire waiting = irqRequest && ackEn && !vectorAck;
   wire fire = waiting && cnt_ff == ackDelay;

   // Accept an offer after ackDelay cycles; record it at the edge where it is taken
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff <= 4'h0;
         vectorAck <= 1'b0;
         retiPulse <= 1'b0;
         lastSrc <= 5'h0;
         lastPri <= 2'h0;
         ackCount <= 8'h0;
      end
      else
      begin
         vectorAck <= fire;
         retiPulse <= retiReq;
         cnt_ff <= (waiting && !fire) ? cnt_ff + 4'h1 : 4'h0;
         if (vectorAck && irqRequest)
         begin
            lastSrc <= irqSource;
            lastPri <= irqPriority;
            ackCount <= ackCount + 8'h1;
         end
      end
   end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero wait state slave, core model as far side
// Notes: Bus tasks follow single AHB-Lite word transfers
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [50:0] flagSetPulse = 51'h0;
   logic [3:0] extIrqPin = 4'hf;
   logic [3:0] ackDelay = 4'h0;
   logic ackEn = 1'b0;
   logic retiReq = 1'b0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, vectorAck, retiPulse, irqRequest;
   wire [4:0] irqSource, lastSrc;
   wire [1:0] irqPriority, lastPri;
   wire [7:0] ackCount;
   int err_total = 0;
   int checks = 0;

   always #20 clk = ~clk;

   vic_controller u_vic_controller (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flagSetPulse(flagSetPulse), .extIrqPin(extIrqPin),
      .vectorAck(vectorAck), .retiPulse(retiPulse), .irqRequest(irqRequest), .irqSource(irqSource),
      .irqPriority(irqPriority));
   vic_core_model u_vic_core_model (.clk(clk), .rst_b(rst_b), .irqRequest(irqRequest), .irqSource(irqSource),
      .irqPriority(irqPriority), .ackEn(ackEn), .ackDelay(ackDelay), .retiReq(retiReq),
      .vectorAck(vectorAck), .retiPulse(retiPulse), .lastSrc(lastSrc), .lastPri(lastPri), .ackCount(ackCount));

   ////////////////////////////////////////////////////////////////
   // Checking and closing
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task close_out;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Source number of each flag bit
   function automatic logic [4:0] srcOf(input int b);
      case (b) inside
         [0:3]: return b[4:0];
         [4:5]: return 5'h04;
         [6:7]: return 5'h05;
         [8:11]: return b[4:0] - 5'h02;
         [12:18]: return 5'h0b;
         [19:20]: return 5'h0c;
         [21:23]: return b[4:0] - 5'h08;
         [24:26]: return 5'h10;
         27: return 5'h11;
         [28:29]: return 5'h12;
         [30:32]: return 5'h13;
         [33:34]: return 5'h14;
         [35:36]: return b[4:0] - 5'h0d;
         [37:43]: return 5'h0a;
         default: return 5'h15;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////
   // Bus and core helpers
   task automatic waitRdy;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         chk("ready", 32'h1, 32'h0);
         close_out();
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {26'h0, a};
      hwrite <= wr;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      q = hrdata;
   endtask
   task automatic pulse(input logic [50:0] m);
      flagSetPulse <= m;
      @(posedge clk);
      flagSetPulse <= 51'h0;
   endtask
   task automatic reti;
      retiReq <= 1'b1;
      @(posedge clk);
      retiReq <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic waitAck;
      logic [7:0] c0;
      int n;
      c0 = ackCount;
      n = 0;
      while (ackCount === c0 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      if (ackCount === c0)
      begin
         chk("ack wait", 32'h1, 32'h0);
         close_out();
      end
   endtask
   // Take one offer, check it, clear its flag in software, return
   task automatic serve(input int b, input logic [4:0] s, input logic [1:0] p);
      logic [5:0] a;
      a = b < 32 ? 6'h18 : 6'h1c;
      waitAck();
      chk("source", s, lastSrc);
      chk("level", p, lastPri);
      repeat (3) @(posedge clk);
      chk("no preempt", 32'h0, irqRequest);
      bus(1'b0, 6'h20, 32'h0);
      chk("status", {20'h0, p, s, 1'b0, 4'h1 << p}, q);
      bus(1'b0, a, 32'h0);
      chk("flag after ack", !(b == 0 || b == 1 || b == 3), q[b % 32]);
      bus(1'b1, a, q & ~(32'h1 << (b % 32)));
      reti();
   endtask

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a <= 32; a += 4)
      begin
         bus(1'b0, a[5:0], 32'h0);
         chk("reset value", 32'h0, q);
      end
      bus(1'b1, 6'h00, 32'hff);
      bus(1'b0, 6'h00, 32'h0);
      chk("main enable", 32'hbf, q);
      bus(1'b1, 6'h24, 32'hff);
      bus(1'b0, 6'h24, 32'h0);
      chk("unmapped", 32'h0, q);
      bus(1'b1, 6'h04, 32'h0c);
      bus(1'b1, 6'h08, 32'hff);
      bus(1'b1, 6'h0c, 32'hff);
      bus(1'b0, 6'h0c, 32'h0);
      chk("ext enable two", 32'hff, q);
      ackEn <= 1'b1;
      for (int b = 0; b < 51; b++)
      begin
         if (!(b inside {0, 2, 8, 9}))
         begin
            ackDelay <= b[0] ? 4'h5 : 4'h0;
            pulse(51'h1 << b);
            serve(b, srcOf(b), 2'h0);
         end
      end
      // Transmit flag routed into the system group with its own source off
      bus(1'b1, 6'h04, 32'h40c);
      bus(1'b1, 6'h00, 32'haf);
      pulse(51'h20);
      serve(5, 5'h0b, 2'h0);
      bus(1'b1, 6'h00, 32'hbf);
      bus(1'b1, 6'h04, 32'h0c);
      // Four levels and a tie, all raised together
      bus(1'b1, 6'h10, 32'h12);
      bus(1'b1, 6'h14, 32'h110);
      ackDelay <= 4'h3;
      pulse(51'hc52);
      serve(4, 5'h04, 2'h3);
      serve(1, 5'h01, 2'h2);
      serve(10, 5'h08, 2'h1);
      serve(6, 5'h05, 2'h0);
      serve(11, 5'h09, 2'h0);
      // Global and per-source gating
      bus(1'b1, 6'h00, 32'h3f);
      pulse(51'h400);
      repeat (6) @(posedge clk);
      chk("global off", 32'h0, irqRequest);
      bus(1'b1, 6'h08, 32'hfe);
      bus(1'b1, 6'h00, 32'hbf);
      repeat (4) @(posedge clk);
      chk("source off", 32'h0, irqRequest);
      bus(1'b1, 6'h08, 32'hff);
      serve(10, 5'h08, 2'h1);
      // External inputs: falling edge on 0, low level on 1
      bus(1'b1, 6'h04, 32'h0d);
      extIrqPin <= 4'he;
      serve(0, 5'h00, 2'h0);
      extIrqPin <= 4'hd;
      waitAck();
      chk("level source", 32'h2, lastSrc);
      extIrqPin <= 4'hf;
      repeat (6) @(posedge clk);
      bus(1'b0, 6'h18, 32'h0);
      chk("level flag follows pin", 32'h0, q[2]);
      reti();
      close_out();
   end
endmodule
